// file: lhu_fifo.sv
// Purpose: small valid/ready FIFO for register write-back words
// Assumes: single clock, asynchronous active-high reset
// Notes:   full/empty are exact; output data is read straight from memory at the read pointer
`timescale 1ns/1ps
`default_nettype none
module lhu_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    // room while fewer than DEPTH words are held; empty must accept
    assign inReady  = (count_reg < (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];

    // storage and pointers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doPop)  rdPtr_reg <= rdPtr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // memory has no reset on purpose
    always_ff @(posedge ref_clk) begin
        if (doPush) mem[wrPtr_reg] <= inData;
    end
endmodule : lhu_fifo
`default_nettype wire

// file: lhu_load_unit.sv
// Purpose: load execution for half-word, byte-reverse, multiple, string
//          and reserve loads: address, formatting, write-back, checks
// Assumes: data memory answers one word per request in order; register
//          file reads are combinational on the same clock
// Notes:   write-backs go through an 8-word FIFO toward the register file
// Operation
// - sign half loads: half in low 16 bits, its top bit replicated above
// - zero half loads: half in low 16 bits, upper 16 bits cleared
// - address is base-or-zero plus index, or plus sign-extended offset
// - update forms write the computed address back into the base
// - update half forms invalid when base is zero or equals dest
// - indexed update halves: primary 0x1F, extended 0x177 signed, 0x137 zero
// - primaries 0x2B signed update, 0x28 zero, 0x29 zero update, 0x2E multi
// - byte-reversed half: swap two bytes, clear upper 16 bits
// - byte-reversed word: reverse all four bytes
// - byte-reversed loads take the same cycles as ordinary loads
// - multiple: 32 minus dest words, dest to r31, address plus four each
// - multiple raises alignment fault on address not multiple of four
// - multiple and immediate string invalid if base lies in loaded range
// - immediate string count from field, zero means 32, address base-or-zero
// - indexed string count from exception reg low seven bits, ceil n/4
// - strings fill registers high byte first, wrapping r31 to r0
// - last partly filled string register has its low bytes cleared
// - indexed string with zero count loads nothing
// - indexed string: base/index in range illegal; dest equal them invalid
// - reserve load loads word and replaces reservation address
// - reserve load raises alignment fault on unaligned address
`timescale 1ns/1ps
`default_nettype none
module lhu_load_unit (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 instValid,
    input  wire logic [31:0]          instWord,
    output logic                      instReady,
    output logic [4:0]                rdAddrA,
    output logic [4:0]                rdAddrB,
    input  wire logic [31:0]          rdDataA,
    input  wire logic [31:0]          rdDataB,
    input  wire logic [6:0]           fixedPointExceptionReg,
    output logic                      memReq,
    output logic [31:0]               memAddr,
    input  wire logic                 memAck,
    input  wire logic [31:0]          memData,
    output logic                      gprWrValid,
    input  wire logic                 gprWrReady,
    output lhu_pkg::lhu_gpr_wr_t      gprWr,
    output logic                      excValid,
    output lhu_pkg::lhu_exc_t         exc,
    output logic                      rsvValid,
    output logic [31:0]               rsvAddr
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001, S_ADDR = 4'b0010,
        S_MEM  = 4'b0100, S_UPD  = 4'b1000
    } lhu_state_t;

    lhu_state_t       state_reg, state_next;
    lhu_pkg::lhu_kind_t kind_reg;
    logic [31:0]      inst_reg;
    logic [31:0]      addr_reg;
    logic [31:0]      ea_reg;
    logic [6:0]       bytesLeft_reg;
    logic [4:0]       dest_reg;
    logic             upd_reg;
    logic             memReq_reg;
    logic             excValid_reg;
    lhu_pkg::lhu_exc_t exc_reg;
    logic             rsvValid_reg;
    logic [31:0]      rsvAddr_reg;
    logic             fifoInValid;
    logic             fifoInReady;
    lhu_pkg::lhu_gpr_wr_t fifoIn;
    logic [6:0]       xcnt_s1_reg, xcnt_reg;

    // ------------------------------------------------------------
    // decode of the held instruction
    // ------------------------------------------------------------
    wire [5:0] opcd  = inst_reg[31:lhu_pkg::POS_OPCD];
    wire [4:0] fRd   = inst_reg[25:lhu_pkg::POS_RD];
    wire [4:0] fRa   = inst_reg[20:lhu_pkg::POS_RA];
    wire [4:0] fRb   = inst_reg[15:lhu_pkg::POS_RB];
    wire [9:0] fXo   = inst_reg[10:lhu_pkg::POS_XO];
    wire       isExt = (opcd == lhu_pkg::OP_EXT);
    wire isLhsu  = opcd == lhu_pkg::OP_LHSU;
    wire isLhzu  = opcd == lhu_pkg::OP_LHZU;
    wire isLhsux = isExt && fXo == lhu_pkg::XO_LHSUX;
    wire isLhzux = isExt && fXo == lhu_pkg::XO_LHZUX;
    wire isHalfS = opcd == lhu_pkg::OP_LHS || isLhsu || isLhsux ||
                   (isExt && fXo == lhu_pkg::XO_LHSX);
    wire isHalfZ = opcd == lhu_pkg::OP_LHZ || isLhzu || isLhzux ||
                   (isExt && fXo == lhu_pkg::XO_LHZX);
    wire isHbr   = isExt && fXo == lhu_pkg::XO_LHBRX;
    wire isWbr   = isExt && fXo == lhu_pkg::XO_LWBRX;
    wire isMulti = opcd == lhu_pkg::OP_LMW;
    wire isStrI  = isExt && fXo == lhu_pkg::XO_LSWI;
    wire isStrX  = isExt && fXo == lhu_pkg::XO_LSWX;
    wire isRsv   = isExt && fXo == lhu_pkg::XO_LWRSV;
    wire isUpd   = isLhsu || isLhzu || isLhsux || isLhzux;
    wire isDisp  = !isExt;

    // in-range test for a register inside a wrapped run of nr registers
    function automatic logic inRun(input logic [4:0] r, input logic [4:0] d,
                                   input logic [5:0] nr);
        logic [4:0] ofs;
        ofs = r - d;
        return nr != 6'h00 && {1'b0, ofs} < nr;
    endfunction : inRun

    // ------------------------------------------------------------
    // counts and address
    // ------------------------------------------------------------
    wire [4:0]  nbField  = fRb;
    wire [6:0]  strCnt   = isStrI ? ((nbField == 5'h00) ?
                           lhu_pkg::STR_IMM_ZERO_CNT : {2'b00, nbField})
                           : xcnt_reg;
    // one spare bit so a count of 127 does not wrap before the divide
    wire [5:0]  strRegs  = 6'(({1'b0, strCnt} + 8'h03) >> 2);
    wire [5:0]  multRegs = 6'(6'd32 - {1'b0, fRd});
    wire [31:0] baseVal  = (fRa == 5'h00) ? 32'h0000_0000 : rdDataA;
    wire [31:0] offVal   = isDisp ? {{16{inst_reg[15]}}, inst_reg[15:0]}
                           : (isStrI ? 32'h0000_0000 : rdDataB);
    wire [31:0] eaCalc   = baseVal + offVal;
    wire badUpd   = isUpd && (fRa == 5'h00 || fRa == fRd);
    wire badMulti = isMulti && inRun(fRa, fRd, multRegs);
    wire badStrI  = isStrI && inRun(fRa, fRd, strRegs);
    wire badStrX  = isStrX && (fRd == fRa || fRd == fRb);
    wire illStrX  = isStrX && (inRun(fRa, fRd, strRegs) ||
                    inRun(fRb, fRd, strRegs));
    wire misAlign = (isMulti || isRsv) && eaCalc[1:0] != 2'b00;
    wire anyBad   = badUpd || badMulti || badStrI || badStrX || illStrX;
    wire noKind   = !(isHalfS || isHalfZ || isHbr || isWbr || isMulti ||
                      isStrI || isStrX || isRsv);

    assign rdAddrA = fRa;
    assign rdAddrB = fRb;

    // ------------------------------------------------------------
    // data formatting (same path for all kinds, no extra cycle)
    // ------------------------------------------------------------
    wire [15:0] halfW = addr_reg[1] ? memData[15:0] : memData[31:16];
    wire [1:0]  lane  = 2'(bytesLeft_reg);
    wire [31:0] strMask = (bytesLeft_reg >= 7'h04) ? 32'hFFFF_FFFF :
                          (lane == 2'd3) ? 32'hFFFF_FF00 :
                          (lane == 2'd2) ? 32'hFFFF_0000 : 32'hFF00_0000;
    wire [31:0] fmtData =
        (kind_reg == lhu_pkg::K_HALF_S) ? {{16{halfW[15]}}, halfW} :
        (kind_reg == lhu_pkg::K_HALF_Z) ? {16'h0000, halfW} :
        (kind_reg == lhu_pkg::K_HALF_BR) ?
            {16'h0000, halfW[7:0], halfW[15:8]} :
        (kind_reg == lhu_pkg::K_WORD_BR) ? {memData[7:0], memData[15:8],
            memData[23:16], memData[31:24]} :
        (kind_reg == lhu_pkg::K_STR) ? (memData & strMask) :
        memData;
    wire lastBeat = (kind_reg == lhu_pkg::K_MULTI) ? (dest_reg == 5'd31) :
                    (kind_reg == lhu_pkg::K_STR) ? (bytesLeft_reg <= 7'h04) :
                    1'b1;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: if (instValid) state_next = S_ADDR;
            S_ADDR: begin
                if (noKind || anyBad || misAlign) state_next = S_IDLE;
                else if (isStrX && strCnt == 7'h00) state_next = S_IDLE;
                else state_next = S_MEM;
            end
            S_MEM: if (memAck && fifoInReady && lastBeat)
                       state_next = upd_reg ? S_UPD : S_IDLE;
            S_UPD: if (fifoInReady) state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    // memory is held off while the FIFO is full, so no word is dropped
    assign fifoInValid = (state_reg == S_MEM && memAck) ||
                         (state_reg == S_UPD);
    assign fifoIn.dest = (state_reg == S_UPD) ? fRa : dest_reg;
    assign fifoIn.data = (state_reg == S_UPD) ? ea_reg : fmtData;
    assign instReady   = (state_reg == S_IDLE);
    assign memReq      = memReq_reg;
    assign memAddr     = addr_reg;
    assign excValid    = excValid_reg;
    assign exc         = exc_reg;
    assign rsvValid    = rsvValid_reg;
    assign rsvAddr     = rsvAddr_reg;

    // count byte from the exception register is synchronised first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xcnt_s1_reg <= '0;
            xcnt_reg    <= '0;
        end else begin
            xcnt_s1_reg <= fixedPointExceptionReg;
            xcnt_reg    <= xcnt_s1_reg;
        end
    end

    // sequencing registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= S_IDLE;
            inst_reg      <= lhu_pkg::RST_WORD;
            kind_reg      <= lhu_pkg::K_NONE;
            addr_reg      <= lhu_pkg::RST_WORD;
            ea_reg        <= lhu_pkg::RST_WORD;
            bytesLeft_reg <= '0;
            dest_reg      <= '0;
            upd_reg       <= 1'b0;
            memReq_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_IDLE && instValid) inst_reg <= instWord;
            if (state_reg == S_ADDR) begin
                addr_reg      <= eaCalc;
                ea_reg        <= eaCalc;
                dest_reg      <= fRd;
                upd_reg       <= isUpd;
                bytesLeft_reg <= strCnt;
                memReq_reg    <= (state_next == S_MEM);
                kind_reg <= isHalfS ? lhu_pkg::K_HALF_S :
                            isHalfZ ? lhu_pkg::K_HALF_Z :
                            isHbr   ? lhu_pkg::K_HALF_BR :
                            isWbr   ? lhu_pkg::K_WORD_BR :
                            isMulti ? lhu_pkg::K_MULTI :
                            (isStrI || isStrX) ? lhu_pkg::K_STR :
                            isRsv   ? lhu_pkg::K_RSV : lhu_pkg::K_NONE;
            end else if (state_reg == S_MEM && memAck && fifoInReady) begin
                addr_reg      <= addr_reg + lhu_pkg::WORD_STEP;
                dest_reg      <= dest_reg + 5'd1;
                bytesLeft_reg <= bytesLeft_reg - 7'h04;
                memReq_reg    <= !lastBeat;
            end else if (state_reg == S_MEM) begin
                memReq_reg    <= fifoInReady;
            end
        end
    end

    // exception report and reservation, one pulse per fault
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            excValid_reg <= 1'b0;
            exc_reg      <= '0;
            rsvValid_reg <= 1'b0;
            rsvAddr_reg  <= lhu_pkg::RST_WORD;
        end else begin
            excValid_reg <= (state_reg == S_ADDR) &&
                            (anyBad || misAlign);
            exc_reg.align   <= misAlign;
            exc_reg.invalid <= badUpd || badMulti || badStrI || badStrX;
            exc_reg.illegal <= illStrX;
            exc_reg.addr    <= eaCalc;
            if (state_reg == S_ADDR && isRsv && !misAlign) begin
                rsvValid_reg <= 1'b1;
                rsvAddr_reg  <= {eaCalc[31:2], 2'b00};
            end
        end
    end

    // ------------------------------------------------------------
    // write-back buffer
    // ------------------------------------------------------------
    lhu_fifo #(
        .WIDTH ($bits(lhu_pkg::lhu_gpr_wr_t)),
        .DEPTH (lhu_pkg::FIFO_DEPTH)
    ) u_wb_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (gprWrValid),
        .outReady (gprWrReady),
        .outData  (gprWr)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fault_no_mem;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == S_ADDR && (anyBad || misAlign)) |=> !memReq;
    endproperty
    a_fault_no_mem: assert property (p_fault_no_mem)
        else $error("faulting load issued memory access");

    property p_fault_pulse;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == S_ADDR && misAlign) |=> excValid && exc.align;
    endproperty
    a_fault_pulse: assert property (p_fault_pulse)
        else $error("alignment fault not reported");

    property p_rsv_set;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == S_ADDR && isRsv && !misAlign)
            |=> rsvValid && rsvAddr == {$past(eaCalc[31:2]), 2'b00};
    endproperty
    a_rsv_set: assert property (p_rsv_set)
        else $error("reservation address not captured");

    property p_sign_half;
        @(posedge ref_clk) disable iff (rst)
        (fifoInValid && state_reg == S_MEM && kind_reg == lhu_pkg::K_HALF_S)
            |-> fifoIn.data[31:16] == {16{fifoIn.data[15]}};
    endproperty
    a_sign_half: assert property (p_sign_half)
        else $error("signed half not extended");

    property p_zero_half;
        @(posedge ref_clk) disable iff (rst)
        (fifoInValid && state_reg == S_MEM &&
         (kind_reg == lhu_pkg::K_HALF_Z || kind_reg == lhu_pkg::K_HALF_BR))
            |-> fifoIn.data[31:16] == 16'h0000;
    endproperty
    a_zero_half: assert property (p_zero_half)
        else $error("zero half upper bits not clear");

    property p_word_br;
        @(posedge ref_clk) disable iff (rst)
        (fifoInValid && state_reg == S_MEM && kind_reg == lhu_pkg::K_WORD_BR)
            |-> fifoIn.data[7:0] == memData[31:24];
    endproperty
    a_word_br: assert property (p_word_br)
        else $error("word bytes not reversed");

    sequence s_addr_phase;
        state_reg == S_ADDR && !anyBad && !misAlign && !noKind &&
        (isHbr || isWbr);
    endsequence
    property p_br_latency;
        @(posedge ref_clk) disable iff (rst)
        s_addr_phase |=> memReq;
    endproperty
    a_br_latency: assert property (p_br_latency)
        else $error("byte-reverse load delayed");

    property p_step;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == S_MEM && memAck && fifoInReady && !lastBeat)
            |=> addr_reg == $past(addr_reg) + 32'h0000_0004;
    endproperty
    a_step: assert property (p_step)
        else $error("multi address not advanced by four");

    property p_upd_wb;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == S_UPD) |-> fifoIn.dest == fRa && fifoIn.data == ea_reg;
    endproperty
    a_upd_wb: assert property (p_upd_wb)
        else $error("base update write wrong");
endmodule : lhu_load_unit
`default_nettype wire

// file: lhu_mem_model.sv
// Purpose: data memory stand-in, one word per ack, sometimes late
// Assumes: word content depends only on the word address
// Notes:   data is inverted off ack so stale values never match
`timescale 1ns/1ps
`default_nettype none
module lhu_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    output logic             memAck,
    output logic [31:0]      memData
);
    logic        go;
    logic [31:0] w;
    // hold back one ack in three to show slow answers
    always @(negedge ref_clk) go <= $urandom % 3 != 0;
    assign w       = {memAddr[31:2], 2'h0} * 32'h9E37_79B1;
    assign memAck  = memReq & go;
    assign memData = memAck ? w : ~w;
endmodule : lhu_mem_model
`default_nettype wire

// file: lhu_pkg.sv
// Purpose: shared constants and types for the half/multi/string load unit
// Assumes: 32-bit words, big-endian bit numbering as in the ISA (bit 0 = MSB)
// Notes:   opcode values, field positions and reset values live here
`default_nettype none
package lhu_pkg;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [5:0] OP_EXT      = 6'h1F;
    localparam logic [5:0] OP_LHS      = 6'h2A;
    localparam logic [5:0] OP_LHSU     = 6'h2B;
    localparam logic [5:0] OP_LHZ      = 6'h28;
    localparam logic [5:0] OP_LHZU     = 6'h29;
    localparam logic [5:0] OP_LMW      = 6'h2E;
    localparam logic [9:0] XO_LHSUX    = 10'h177;
    localparam logic [9:0] XO_LHSX     = 10'h157;
    localparam logic [9:0] XO_LHZUX    = 10'h137;
    localparam logic [9:0] XO_LHZX     = 10'h117;
    localparam logic [9:0] XO_LHBRX    = 10'h316;
    localparam logic [9:0] XO_LWBRX    = 10'h216;
    localparam logic [9:0] XO_LSWI     = 10'h255;
    localparam logic [9:0] XO_LSWX     = 10'h215;
    localparam logic [9:0] XO_LWRSV    = 10'h014;
    // ------------------------------------------------------------
    // field positions (verilog bit index, MSB = 31)
    // ------------------------------------------------------------
    localparam int POS_OPCD = 26;
    localparam int POS_RD   = 21;
    localparam int POS_RA   = 16;
    localparam int POS_RB   = 11;
    localparam int POS_XO   = 1;
    localparam int POS_XCNT = 0;   // byte count in exception reg [25:31]
    localparam int NUM_REGS = 32;
    localparam int FIFO_DEPTH = 8;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [6:0]  STR_IMM_ZERO_CNT = 7'h20;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        K_HALF_S = 4'h0, K_HALF_Z = 4'h1, K_HALF_BR = 4'h2,
        K_WORD_BR = 4'h3, K_MULTI = 4'h4, K_STR = 4'h5,
        K_RSV = 4'h6, K_NONE = 4'h7
    } lhu_kind_t;

    typedef struct packed {
        logic [4:0]  dest;
        logic [31:0] data;
    } lhu_gpr_wr_t;

    typedef struct packed {
        logic        align;
        logic        invalid;
        logic        illegal;
        logic [31:0] addr;
    } lhu_exc_t;
endpackage : lhu_pkg
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the load unit against a queue model
// Assumes: register file is an array here, read in the same cycle
// Notes:   ready drops in bursts so the write-back FIFO fills up
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk, rst, instValid, instReady, memReq, memAck, ex;
    logic        gprWrValid, gprWrReady, excValid, rsvValid;
    logic [31:0] instWord, memAddr, memData, rsvAddr, general_register [32];
    logic [4:0]  rdAddrA, rdAddrB;
    logic [6:0]  fpx;
    logic [36:0] got [$];
    int          bad_count, n_checks, cyc;
    lhu_pkg::lhu_gpr_wr_t gprWr;
    lhu_pkg::lhu_exc_t    exc, exs;
    lhu_load_unit lhu_load_unit_i (.ref_clk, .rst, .instValid, .instWord,
        .instReady, .rdAddrA, .rdAddrB, .rdDataA(general_register[rdAddrA]),
        .rdDataB(general_register[rdAddrB]), .fixedPointExceptionReg(fpx), .memReq,
        .memAddr, .memAck, .memData, .gprWrValid, .gprWrReady, .gprWr,
        .excValid, .exc, .rsvValid, .rsvAddr);
    lhu_mem_model lhu_mem_model_i (.ref_clk, .memReq, .memAddr, .memAck,
        .memData);
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ready low 16 of every 64 cycles, else random
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        gprWrReady <= cyc[5:4] != 0 && $urandom % 4 != 0;
    end
    // collect write-backs and exception pulses
    always @(posedge ref_clk) begin
        if (gprWrValid && gprWrReady) got.push_back(gprWr);
        if (excValid) ex = 1;
        if (excValid) exs = exc;
    end
    function automatic logic [31:0] mw(input logic [31:0] a);
        return {a[31:2], 2'h0} * 32'h9E37_79B1;
    endfunction : mw
    task automatic cmp(input logic [36:0] g, input logic [36:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask : cmp
    task automatic tally_and_finish;
        if (bad_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic tick(inout int i);
        i++;
        if (i > 3000) begin
            bad_count++;
            tally_and_finish;
        end
        @(negedge ref_clk);
    endtask : tick
    // expected writes worked out first, then issue and compare
    task automatic run(input int k, logic [5:0] op, logic [9:0] xo,
                       logic [4:0] rd, ra, rb, logic [15:0] d, int ee);
        logic [31:0] ea, w, v;
        logic [36:0] q [$];
        logic [4:0]  r;
        int          n, i, j;
        if (k == 6) fpx = d[6:0];
        repeat (4) @(negedge ref_clk); // count passes two sync flops
        ea = (ra == 0 ? 32'h0 : general_register[ra]) + (op != lhu_pkg::OP_EXT ?
             {{16{d[15]}}, d} : k == 5 ? 32'h0 : general_register[rb]);
        w = mw(ea);
        v = ea[1] ? w : w >> 16;
        v = k == 0 ? {{16{v[15]}}, v[15:0]} : k == 1 ? {16'h0, v[15:0]} :
            k == 2 ? {16'h0, v[7:0], v[15:8]} :
            k == 3 ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        n = k == 5 ? (rb == 0 ? 32 : rb) : k == 6 ? d : 0;
        if (ee == 0 && (k < 4 || k == 7)) q.push_back({rd, v});
        for (i = rd; ee == 0 && k == 4 && i < 32; i++)
            q.push_back({i[4:0], mw(ea + 4 * (i - rd))});
        r = rd;
        for (i = 0; ee == 0 && i < n; i += 4) begin
            v = 0;
            for (j = i; j < i + 4 && j < n; j++) begin
                w = ea + j;
                v[31 - 8 * (j - i) -: 8] = 8'(mw(w) >> 8 * (3 - w[1:0]));
            end
            q.push_back({r, v});
            r++;
        end
        if (ee == 0 && (op == lhu_pkg::OP_LHSU || op == lhu_pkg::OP_LHZU ||
                xo == lhu_pkg::XO_LHSUX || xo == lhu_pkg::XO_LHZUX))
            q.push_back({ra, ea});
        got.delete();
        ex = 0;
        instValid = 1;
        instWord = {op, rd, ra, op == lhu_pkg::OP_EXT ? {rb, xo, 1'b0} : d};
        for (i = 0; !instReady;) tick(i);
        @(negedge ref_clk);
        instValid = 0;
        for (i = 0; !instReady || got.size() < q.size();) tick(i);
        repeat (4) @(negedge ref_clk);
        cmp(37'(got.size()), 37'(q.size()));
        foreach (q[x]) cmp(got[x], q[x]);
        cmp({33'h0, ex, ex ? {exs.align, exs.invalid, exs.illegal} : 3'h0},
            {33'h0, ee != 0, ee == 1, ee == 2, ee == 3});
        if (k == 7 && ee == 0)
            cmp({4'h0, rsvValid, rsvAddr}, {5'h1, ea & 32'hFFFF_FFFC});
    endtask : run
    initial begin
        void'($urandom(32'h50EC8EAB));
        {rst, instValid, instWord, fpx} = {1'b1, 40'h0};
        foreach (general_register[x]) general_register[x] = $urandom & 32'hFFFF_FFFC;
        general_register[5][0] = 1'b1; // odd index for a misaligned reserve
        repeat (12) @(negedge ref_clk);
        rst = 0;
        run(0, lhu_pkg::OP_LHS, 0, 3, 0, 0, 16'h0012, 0);
        run(0, lhu_pkg::OP_LHSU, 0, 4, 6, 0, 16'hFFFE, 0);
        run(0, lhu_pkg::OP_EXT, lhu_pkg::XO_LHSUX, 7, 8, 9, 0, 0);
        run(1, lhu_pkg::OP_LHZ, 0, 10, 11, 0, 16'h8002, 0);
        run(1, lhu_pkg::OP_EXT, lhu_pkg::XO_LHZUX, 14, 15, 16, 0, 0);
        run(1, lhu_pkg::OP_LHZU, 0, 12, 12, 0, 16'h0004, 2);
        run(2, lhu_pkg::OP_EXT, lhu_pkg::XO_LHBRX, 17, 18, 19, 0, 0);
        run(3, lhu_pkg::OP_EXT, lhu_pkg::XO_LWBRX, 20, 0, 22, 0, 0);
        run(4, lhu_pkg::OP_LMW, 0, 8, 3, 0, 16'h0010, 0);
        run(4, lhu_pkg::OP_LMW, 0, 30, 2, 0, 16'h0001, 1);
        run(4, lhu_pkg::OP_LMW, 0, 29, 30, 0, 0, 2);
        run(5, lhu_pkg::OP_EXT, lhu_pkg::XO_LSWI, 28, 10, 0, 0, 0);
        run(6, lhu_pkg::OP_EXT, lhu_pkg::XO_LSWX, 31, 11, 12, 6, 0);
        run(6, lhu_pkg::OP_EXT, lhu_pkg::XO_LSWX, 9, 10, 2, 9, 3);
        run(6, lhu_pkg::OP_EXT, lhu_pkg::XO_LSWX, 9, 1, 2, 0, 0);
        run(7, lhu_pkg::OP_EXT, lhu_pkg::XO_LWRSV, 23, 24, 25, 0, 0);
        run(7, lhu_pkg::OP_EXT, lhu_pkg::XO_LWRSV, 23, 24, 5, 0, 1);
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
